// [hw/clut_pkg.sv]
// Overview of operation
// - Command pins pick pointer (x0), palette (01) or overlay colours (11).
// - Entry pointer advances by one after every blue read or write.
// - Component counter steps red, green, blue; clears on pointer write.
// - Entry picks palette slot; overlay bank uses entries 1 to 3, entry 0 reserved.
// - Red and green writes wait in holding registers; blue commits 24 bits.
// - Pixels go reference black during blue writes or any colour read.
// - Host port runs with no timing relation to the pixel clock.
// - Each rising pixel clock latches pixel index and overlay select.
// - Every pixel cycle the chosen 24-bit colour drives three 8-bit outputs.
// - Sync and blank share the pixel data pipeline depth.
// - Pixel pipeline works for pixel clocks up to 40 MHz.
// - Write data is taken at the write strobe's rising edge with select low.
// - Non-zero overlay select ignores pixel index and uses that overlay colour.
// - Low blank forces all colour outputs to the blanking level.
package clut_pkg;
   localparam logic [1:0] CMD_ADDR_A     = 2'h0;
   localparam logic [1:0] CMD_PALETTE    = 2'h1;
   localparam logic [1:0] CMD_ADDR_B     = 2'h2;
   localparam logic [1:0] CMD_OVERLAY    = 2'h3;
   localparam logic [1:0] COMP_RED       = 2'h0;
   localparam logic [1:0] COMP_GREEN     = 2'h1;
   localparam logic [1:0] COMP_BLUE      = 2'h2;
   localparam logic [7:0] OVL_RESERVED   = 8'h00;
   localparam logic [7:0] OVL_LAST_ENTRY = 8'h03;
   localparam logic [7:0] ENTRY_STEP     = 8'h01;
   localparam logic [7:0] LEVEL_BLACK    = 8'h00;
   localparam logic [7:0] LEVEL_BLANK    = 8'h00;
   localparam int         PAL_ENTRIES    = 256;
   localparam int         OVL_ENTRIES    = 3;
   localparam int         COLOUR_W       = 24;
   localparam int         CLK_MHZ        = 100;
   localparam int         PIX_MAX_MHZ    = 40;
   // Shortest pixel period in core cycles, rounded down; must stay at least two for edge capture.
   localparam int         PIX_MIN_CYCLES = CLK_MHZ / PIX_MAX_MHZ;
   localparam int         FIFO_WIDTH     = 11;
   localparam int         FIFO_DEPTH     = 8;
   localparam int         FIFO_RD_BIT    = 10;
endpackage

// [hw/word_fifo.sv]
`timescale 1ns/1ns
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // Filling side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic             push;
   logic             pop;

   assign in_ready  = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data  = mem_ff[rd_ptr_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_count_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
      count_ff <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

// [hw/color_palette_lookup_logic.sv]
`timescale 1ns/1ns
module color_palette_lookup_logic
   import clut_pkg::*;
(
   // Core clock and reset.
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // Host port pins.
   input  wire logic       chip_select_n,
   input  wire logic       read_strobe_n,
   input  wire logic       write_strobe_n,
   input  wire logic       command_select_low,
   input  wire logic       command_select_high,
   input  wire logic [7:0] host_data_bus_in,
   output logic      [7:0] host_data_bus_out,
   output logic            host_data_bus_oe,
   output logic            host_busy,
   // Video port pins.
   input  wire logic       pixel_clock,
   input  wire logic [7:0] pixel_index,
   input  wire logic       overlay_select_low,
   input  wire logic       overlay_select_high,
   input  wire logic       sync_n_in,
   input  wire logic       blank_n_in,
   // Converter side.
   output logic      [7:0] red_out,
   output logic      [7:0] green_out,
   output logic      [7:0] blue_out,
   output logic            sync_n_out,
   output logic            blank_n_out
);
   ////////////////////////////////////////////////////////////////////////////
   logic [1:0]  pclk_sync_ff;
   logic        pclk_prev_ff;
   logic [7:0]  idx_m_ff, idx_s_ff;
   logic [1:0]  ovl_m_ff, ovl_s_ff;
   logic [1:0]  vctl_m_ff, vctl_s_ff;
   logic [2:0]  strb_m_ff, strb_s_ff;
   logic [1:0]  cmd_m_ff, cmd_s_ff;
   logic [7:0]  data_m_ff, data_s_ff;
   logic        pix_en;

   // Every pin crosses two flops; nothing else looks at the first stage.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pclk_sync_ff <= '0;
         pclk_prev_ff <= 1'b0;
         idx_m_ff     <= '0;
         idx_s_ff     <= '0;
         ovl_m_ff     <= '0;
         ovl_s_ff     <= '0;
         vctl_m_ff    <= '1;
         vctl_s_ff    <= '1;
         strb_m_ff    <= '1;
         strb_s_ff    <= '1;
         cmd_m_ff     <= '0;
         cmd_s_ff     <= '0;
         data_m_ff    <= '0;
         data_s_ff    <= '0;
      end else begin
         pclk_sync_ff <= {pclk_sync_ff[0], pixel_clock};
         pclk_prev_ff <= pclk_sync_ff[1];
         idx_m_ff     <= pixel_index;
         idx_s_ff     <= idx_m_ff;
         ovl_m_ff     <= {overlay_select_high, overlay_select_low};
         ovl_s_ff     <= ovl_m_ff;
         vctl_m_ff    <= {sync_n_in, blank_n_in};
         vctl_s_ff    <= vctl_m_ff;
         strb_m_ff    <= {chip_select_n, read_strobe_n, write_strobe_n};
         strb_s_ff    <= strb_m_ff;
         cmd_m_ff     <= {command_select_high, command_select_low};
         cmd_s_ff     <= cmd_m_ff;
         data_m_ff    <= host_data_bus_in;
         data_s_ff    <= data_m_ff;
      end
   end

   assign pix_en = pclk_sync_ff[1] && !pclk_prev_ff;

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]        entry_ptr_ff;
   logic [1:0]        comp_cnt_ff;
   logic [7:0]        red_hold_ff;
   logic [7:0]        green_hold_ff;
   logic [COLOUR_W-1:0] palette_ff [PAL_ENTRIES];
   logic [COLOUR_W-1:0] overlay_ff [OVL_ENTRIES];
   logic              wr_act, rd_act, wr_act_ff, rd_act_ff;
   logic [1:0]        wr_cmd_ff;
   logic [7:0]        wr_data_ff;
   logic [1:0]        rd_cmd_ff;
   logic              push_valid, push_ready;
   logic [FIFO_WIDTH-1:0] push_word;
   logic              pop_valid, pop_ready;
   logic [FIFO_WIDTH-1:0] pop_word;
   logic              pop_is_read;
   logic [1:0]        pop_cmd;
   logic [7:0]        pop_data;
   logic              pop_fire;
   logic              in_overlay;
   logic [COLOUR_W-1:0] read_word;
   logic [7:0]        read_byte;

   // Strobe order is {select, read, write}; both strobes low leaves both idle.
   assign wr_act = !strb_s_ff[2] && !strb_s_ff[0] && strb_s_ff[1];
   assign rd_act = !strb_s_ff[2] && !strb_s_ff[1] && strb_s_ff[0];

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_act_ff  <= 1'b0;
         rd_act_ff  <= 1'b0;
         wr_cmd_ff  <= '0;
         wr_data_ff <= '0;
         rd_cmd_ff  <= '0;
      end else begin
         wr_act_ff <= wr_act;
         rd_act_ff <= rd_act;
         if (wr_act) begin
            wr_cmd_ff  <= cmd_s_ff;
            wr_data_ff <= data_s_ff;
         end
         if (rd_act) begin
            rd_cmd_ff <= cmd_s_ff;
         end
      end
   end

   // An access ends only when its own strobe rises; a collapse into the illegal
   // state drops the access instead of committing it.
   always_comb begin
      push_valid = 1'b0;
      push_word  = '0;
      if (wr_act_ff && strb_s_ff[0] && !strb_s_ff[1] == 1'b0) begin
         push_valid = 1'b1;
         push_word  = {1'b0, wr_cmd_ff, wr_data_ff};
      end else if (rd_act_ff && strb_s_ff[1] && !strb_s_ff[0] == 1'b0) begin
         push_valid = 1'b1;
         push_word  = {1'b1, rd_cmd_ff, 8'h00};
      end
   end

   // Accesses drain one per cycle but yield to the pixel lookup, so the
   // colour stores see a single access per cycle.
   word_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_access_fifo (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_word),
      .out_valid (pop_valid),
      .out_ready (pop_ready),
      .out_data  (pop_word)
   );

   assign pop_ready   = !pix_en;
   assign pop_fire    = pop_valid && pop_ready;
   assign pop_is_read = pop_word[FIFO_RD_BIT];
   assign pop_cmd     = pop_word[FIFO_RD_BIT-1:FIFO_RD_BIT-2];
   assign pop_data    = pop_word[7:0];
   assign in_overlay  = (pop_cmd == CMD_OVERLAY);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         entry_ptr_ff <= '0;
         comp_cnt_ff  <= COMP_RED;
      end else if (pop_fire) begin
         if (pop_cmd == CMD_ADDR_A || pop_cmd == CMD_ADDR_B) begin
            if (!pop_is_read) begin
               entry_ptr_ff <= pop_data;
               comp_cnt_ff  <= COMP_RED;
            end
         end else if (comp_cnt_ff == COMP_BLUE) begin
            entry_ptr_ff <= entry_ptr_ff + ENTRY_STEP;
            comp_cnt_ff  <= COMP_RED;
         end else begin
            comp_cnt_ff <= comp_cnt_ff + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (pop_fire && !pop_is_read && pop_cmd[0]) begin
         case (comp_cnt_ff)
            COMP_RED: begin
               red_hold_ff <= pop_data;
            end
            COMP_GREEN: begin
               green_hold_ff <= pop_data;
            end
            COMP_BLUE: begin
               if (!in_overlay) begin
                  palette_ff[entry_ptr_ff] <= {red_hold_ff, green_hold_ff, pop_data};
               end else if (entry_ptr_ff != OVL_RESERVED && entry_ptr_ff <= OVL_LAST_ENTRY) begin
                  overlay_ff[entry_ptr_ff[1:0] - 2'h1] <= {red_hold_ff, green_hold_ff, pop_data};
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read data follows the live pointer; with writes still queued it may lag.
   always_comb begin
      read_word = '0;
      read_byte = '0;
      if (rd_cmd_ff == CMD_PALETTE) begin
         read_word = palette_ff[entry_ptr_ff];
      end else if (entry_ptr_ff != OVL_RESERVED && entry_ptr_ff <= OVL_LAST_ENTRY) begin
         read_word = overlay_ff[entry_ptr_ff[1:0] - 2'h1];
      end
      case (comp_cnt_ff)
         COMP_RED:   read_byte = read_word[23:16];
         COMP_GREEN: read_byte = read_word[15:8];
         default:    read_byte = read_word[7:0];
      endcase
      if (!rd_cmd_ff[0]) begin
         read_byte = entry_ptr_ff;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_data_bus_out <= '0;
         host_data_bus_oe  <= 1'b0;
         host_busy         <= 1'b0;
      end else begin
         host_data_bus_out <= read_byte;
         host_data_bus_oe  <= rd_act && rd_act_ff;
         host_busy         <= !push_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] idx_s1_ff;
   logic [1:0] ovl_s1_ff;
   logic       sync_s1_ff, blank_s1_ff, black_s1_ff;
   logic       black_now;

   assign black_now = (wr_act && cmd_s_ff[0] && comp_cnt_ff == COMP_BLUE) ||
                      (rd_act && cmd_s_ff[0]);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         idx_s1_ff   <= '0;
         ovl_s1_ff   <= '0;
         sync_s1_ff  <= 1'b1;
         blank_s1_ff <= 1'b0;
         black_s1_ff <= 1'b0;
      end else if (pix_en) begin
         idx_s1_ff   <= idx_s_ff;
         ovl_s1_ff   <= ovl_s_ff;
         sync_s1_ff  <= vctl_s_ff[1];
         blank_s1_ff <= vctl_s_ff[0];
         black_s1_ff <= black_now;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         red_out     <= LEVEL_BLANK;
         green_out   <= LEVEL_BLANK;
         blue_out    <= LEVEL_BLANK;
         sync_n_out  <= 1'b1;
         blank_n_out <= 1'b0;
      end else if (pix_en) begin
         sync_n_out  <= sync_s1_ff;
         blank_n_out <= blank_s1_ff;
         if (!blank_s1_ff) begin
            {red_out, green_out, blue_out} <= {3{LEVEL_BLANK}};
         end else if (black_s1_ff) begin
            {red_out, green_out, blue_out} <= {3{LEVEL_BLACK}};
         end else if (ovl_s1_ff != 2'h0) begin
            {red_out, green_out, blue_out} <= overlay_ff[ovl_s1_ff - 2'h1];
         end else begin
            {red_out, green_out, blue_out} <= palette_ff[idx_s1_ff];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_ptr_write_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      pop_fire && !pop_is_read && !pop_cmd[0] |=>
         comp_cnt_ff == COMP_RED && entry_ptr_ff == $past(pop_data))
      else $error("pointer write did not load entry and clear component");

   a_blue_advance: assert property (@(posedge core_clk) disable iff (sys_rst)
      pop_fire && pop_cmd[0] && comp_cnt_ff == COMP_BLUE |=>
         entry_ptr_ff == $past(entry_ptr_ff) + ENTRY_STEP && comp_cnt_ff == COMP_RED)
      else $error("blue access did not advance entry");

   a_comp_modulo: assert property (@(posedge core_clk) disable iff (sys_rst)
      comp_cnt_ff != 2'h3)
      else $error("component counter left modulo three");

   a_illegal_no_push: assert property (@(posedge core_clk) disable iff (sys_rst)
      !strb_s_ff[1] && !strb_s_ff[0] |-> !push_valid && !wr_act && !rd_act)
      else $error("illegal strobe pair produced an access");

   a_blank_forces: assert property (@(posedge core_clk) disable iff (sys_rst)
      pix_en && !blank_s1_ff |=> red_out == LEVEL_BLANK && green_out == LEVEL_BLANK
         && blue_out == LEVEL_BLANK && !blank_n_out)
      else $error("blank did not force blanking level");

   a_black_forces: assert property (@(posedge core_clk) disable iff (sys_rst)
      pix_en && black_s1_ff |=> {red_out, green_out, blue_out} == {3{LEVEL_BLACK}})
      else $error("host access did not force black");

   a_overlay_pick: assert property (@(posedge core_clk) disable iff (sys_rst)
      pix_en && blank_s1_ff && !black_s1_ff && ovl_s1_ff == 2'h2 |=>
         {red_out, green_out, blue_out} == $past(overlay_ff[1]))
      else $error("overlay select did not pick overlay colour");

   a_ctl_aligned: assert property (@(posedge core_clk) disable iff (sys_rst)
      pix_en |=> sync_n_out == $past(sync_s1_ff) && blank_n_out == $past(blank_s1_ff))
      else $error("sync and blank not aligned with pixel pipeline");

   a_drain_yields: assert property (@(posedge core_clk) disable iff (sys_rst)
      pix_en |-> !pop_fire)
      else $error("host access drained during pixel lookup");
endmodule

// [sim/host_video_model.sv]
`timescale 1ns/1ns
module host_video_model
   import clut_pkg::*;
(
   // Core clock.
   input  wire logic       core_clk,
   // Host side.
   output logic            chip_select_n,
   output logic            read_strobe_n,
   output logic            write_strobe_n,
   output logic            command_select_low,
   output logic            command_select_high,
   output logic      [7:0] host_data_bus_in,
   input  wire logic [7:0] host_data_bus_out,
   input  wire logic       host_data_bus_oe,
   // Video side.
   output logic            pixel_clock,
   output logic      [7:0] pixel_index,
   output logic            overlay_select_low,
   output logic            overlay_select_high,
   output logic            sync_n_in,
   output logic            blank_n_in
);
   logic blank_want = 1'b0;
   logic ph         = 1'b0;
   initial begin
      {chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
      {command_select_high, command_select_low, host_data_bus_in} = 10'h000;
      {pixel_clock, pixel_index, overlay_select_high, overlay_select_low} = 11'h000;
      {sync_n_in, blank_n_in} = 2'h2;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Pixel clock at a quarter of the core rate, inside the pixel rate ceiling.
   always @(negedge core_clk) begin
      ph <= ~ph;
      if (ph) begin
         pixel_clock <= ~pixel_clock;
         if (pixel_clock) begin
            pixel_index <= 8'($urandom);
            {overlay_select_high, overlay_select_low} <= 2'($urandom);
            sync_n_in <= 1'($urandom);
            blank_n_in <= blank_want;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Both strobes go low together only when the caller asks for an illegal cycle.
   task automatic access(input logic rd, input logic wr, input logic [1:0] cmd,
                         input logic [7:0] d, input int hold, output logic [8:0] q);
      @(negedge core_clk);
      {command_select_high, command_select_low} = cmd;
      host_data_bus_in = wr ? d : ~host_data_bus_in;
      chip_select_n = 1'b0;
      read_strobe_n = ~rd;
      write_strobe_n = ~wr;
      repeat (hold) @(negedge core_clk);
      // Read data has settled here; the strobes rise only after it is taken.
      q = {host_data_bus_oe, host_data_bus_out};
      {chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
      repeat (2) @(negedge core_clk);
      // Lines are kept two cycles after the strobe is up, then inverted, so stale data cannot pass.
      host_data_bus_in = ~host_data_bus_in;
      {command_select_high, command_select_low} = ~cmd;
      repeat (6) @(negedge core_clk);
   endtask
endmodule

// [sim/color_palette_lookup_logic_tb.sv]
`timescale 1ns/1ns
module color_palette_lookup_logic_tb
   import clut_pkg::*;
;
   logic                  core_clk = 1'b0;
   logic                  sys_rst  = 1'b1;
   logic                  chip_select_n, read_strobe_n, write_strobe_n, host_busy;
   logic                  command_select_low, command_select_high, host_data_bus_oe;
   logic            [7:0] host_data_bus_in, host_data_bus_out, pixel_index;
   logic                  pixel_clock, overlay_select_low, overlay_select_high;
   logic                  sync_n_in, blank_n_in, sync_n_out, blank_n_out;
   logic            [7:0] red_out, green_out, blue_out;
   logic           [13:0] pq[$];
   logic            [8:0] q;
   logic                  act, act_d = 1'b0, mon = 1'b0;
   int                    mismatches = 0, n_compared = 0, cycles = 0, since = 0;
   int                    comp = 0, ent = 0, hr = 0, hg = 0, pal[256], ovl[4];

   always #5 core_clk = ~core_clk;

   color_palette_lookup_logic i_color_palette_lookup_logic (.core_clk, .sys_rst,
      .chip_select_n, .read_strobe_n, .write_strobe_n, .command_select_low,
      .command_select_high, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe,
      .host_busy, .pixel_clock, .pixel_index, .overlay_select_low, .overlay_select_high,
      .sync_n_in, .blank_n_in, .red_out, .green_out, .blue_out, .sync_n_out, .blank_n_out);
   host_video_model i_host_video_model (.core_clk, .chip_select_n, .read_strobe_n,
      .write_strobe_n, .command_select_low, .command_select_high, .host_data_bus_in,
      .host_data_bus_out, .host_data_bus_oe, .pixel_clock, .pixel_index,
      .overlay_select_low, .overlay_select_high, .sync_n_in, .blank_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bad(input string w, input logic [25:0] e, input logic [25:0] g);
      mismatches++;
      $display("BAD %s expected %h seen %h", w, e, g);
   endtask
   task automatic chk_read(input logic [8:0] e, input logic [8:0] g);
      n_compared++;
      if (g !== e) bad("host read", 26'(e), 26'(g));
   endtask
   task automatic chk_pix(input logic [25:0] e, input logic [25:0] g);
      n_compared++;
      if (g !== e) bad("pixel", e, g);
   endtask
   task automatic chk_fifo(input logic [11:0] e, input logic [11:0] g);
      n_compared++;
      if (g !== e) bad("host busy", 26'(e), 26'(g));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Reference model of the host side, updated after each access completes.
   task automatic step();
      if (comp == 2) ent = (ent + 1) % PAL_ENTRIES;
      comp = (comp + 1) % 3;
   endtask
   task automatic wr(input logic [1:0] cmd, input logic [7:0] d, input int h = 6);
      logic [23:0] c;
      c = {hr[7:0], hg[7:0], d};
      i_host_video_model.access(1'b0, 1'b1, cmd, d, h, q);
      chk_fifo(12'h000, 12'(host_busy));
      if (!cmd[0]) begin
         ent = d;
         comp = 0;
      end else begin
         if (comp == 0) hr = d;
         if (comp == 1) hg = d;
         if (comp == 2 && !cmd[1]) pal[ent] = int'(c);
         if (comp == 2 && cmd[1] && ent >= 1 && ent <= OVL_ENTRIES) ovl[ent] = int'(c);
         step();
      end
   endtask
   task automatic rd(input logic [1:0] cmd, input int h = 6);
      logic [23:0] c;
      c = cmd[1] ? ((ent >= 1 && ent <= OVL_ENTRIES) ? 24'(ovl[ent]) : 24'h0) : 24'(pal[ent]);
      i_host_video_model.access(1'b1, 1'b0, cmd, 8'h00, h, q);
      chk_fifo(12'h000, 12'(host_busy));
      if (!cmd[0]) chk_read({1'b1, 8'(ent)}, q);
      else begin
         chk_read({1'b1, 8'(c >> (16 - 8 * comp))}, q);
         step();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Colour reads and blue writes black the picture; pixels near a change are not judged.
   assign act = !chip_select_n && command_select_low
                && (!read_strobe_n || (!write_strobe_n && comp == 2));
   always @(posedge core_clk) begin
      cycles++;
      act_d <= act;
      since <= (act != act_d) ? 0 : since + 1;
      if (cycles == 40000) begin
         mismatches++;
         test_done();
      end
   end
   always @(posedge pixel_clock) begin
      if (mon) pq.push_back({since < 10, act, sync_n_in, blank_n_in, overlay_select_high,
                             overlay_select_low, pixel_index});
   end
   always @(negedge pixel_clock) begin
      logic [13:0] e;
      logic [23:0] col;
      if (pq.size() > 0 && since < 3) pq[$][13] = 1'b1;
      if (pq.size() == 3) begin
         e = pq.pop_front();
         col = 24'(pal[e[7:0]]);
         if (e[9:8] != 2'h0) col = 24'(ovl[e[9:8]]);
         if (e[12]) col = {3{LEVEL_BLACK}};
         if (!e[10]) col = {3{LEVEL_BLANK}};
         if (!e[13]) chk_pix({e[11:10], col}, {sync_n_out, blank_n_out, red_out, green_out,
                                               blue_out});
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [23:0] c;
      void'($urandom(32'h6545));
      repeat (20) @(negedge core_clk);
      sys_rst = 1'b0;
      @(negedge core_clk);
      chk_pix(26'h2000000, {sync_n_out, blank_n_out, red_out, green_out, blue_out});
      chk_read(9'h000, {host_data_bus_oe, host_data_bus_out});
      repeat (10) @(negedge core_clk);
      mon = 1'b1;
      // Accesses are spaced wider than the drain rate, so the access queue never fills.
      chk_fifo(12'h000, 12'(host_busy));
      rd(CMD_ADDR_A);
      wr(CMD_ADDR_B, 8'h00);
      // The palette is loaded while blanked, as a host does during retrace.
      repeat (3 * PAL_ENTRIES) wr(CMD_PALETTE, 8'($urandom));
      rd(CMD_ADDR_A);
      repeat (4) begin
         wr(CMD_ADDR_A, 8'($urandom));
         repeat (3) rd(CMD_PALETTE);
         rd(CMD_ADDR_B);
      end
      rd(CMD_PALETTE);
      wr(CMD_ADDR_A, 8'(ent));
      rd(CMD_PALETTE);
      wr(CMD_ADDR_A, 8'(ent));
      wr(CMD_PALETTE, 8'h5A);
      wr(CMD_PALETTE, 8'hA5);
      wr(CMD_ADDR_A, 8'(ent));
      repeat (3) rd(CMD_PALETTE);
      wr(CMD_ADDR_A, 8'h05);
      i_host_video_model.access(1'b1, 1'b1, CMD_ADDR_A, 8'h09, 6, q);
      rd(CMD_ADDR_A);
      i_host_video_model.access(1'b1, 1'b1, CMD_PALETTE, 8'h09, 6, q);
      repeat (3) rd(CMD_PALETTE);
      wr(CMD_ADDR_A, OVL_RESERVED);
      repeat (3 * (OVL_ENTRIES + 1)) wr(CMD_OVERLAY, 8'($urandom));
      wr(CMD_ADDR_B, OVL_RESERVED);
      repeat (3 * (OVL_ENTRIES + 1)) rd(CMD_OVERLAY);
      rd(CMD_ADDR_A);
      i_host_video_model.blank_want = 1'b1;
      repeat (200) @(negedge core_clk);
      // Rewrite an entry with its own value so the picture itself is unaffected.
      c = 24'(pal[16]);
      wr(CMD_ADDR_A, 8'h10);
      wr(CMD_PALETTE, c[23:16]);
      wr(CMD_PALETTE, c[15:8]);
      wr(CMD_PALETTE, c[7:0], 40);
      wr(CMD_ADDR_A, 8'h10);
      repeat (2) rd(CMD_PALETTE, 40);
      repeat (100) @(negedge core_clk);
      test_done();
   end
endmodule
